// ---- uic_usart.sv ----
// USART core with smart-card rate divider, APB registers, tx and async rx
`timescale 1ns/1ps
`default_nettype none
module uic_usart #(
  parameter int PRESCALE = 8
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  input  wire logic        rxd_i,
  output var  logic        txd_o,
  input  wire logic        sck_i,
  output var  logic        sck_o,
  output var  logic        sck_oe_n_o
);
  import uic_pkg::*;

  if (PRESCALE < 2 || PRESCALE > 256)
  begin : g_bad_prescale
    $error("PRESCALE must lie in 2..256");
  end

  localparam int PW = $clog2(PRESCALE);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  uic_mode_t   mode;
  logic [15:0] baud_divisor;
  logic [10:0] clock_to_bit_ratio;
  logic [3:0]  clock_division_code;
  logic [3:0]  bit_rate_adjust_code;
  logic        rxd_s1, rxd_s2, sck_s1, sck_s2, sck_s3;
  logic        access, commit, wr, rd, hit;
  logic [31:0] rd_val, cmd;
  logic [PW-1:0] pre_cnt;
  logic        pre_tick, src_tick, baud_tick, samp_tick;
  logic [15:0] baud_cnt;
  logic [10:0] ovs;
  logic [11:0] stop_len;
  logic [3:0]  nbits;
  logic [8:0]  dmask;
  logic        check_on;
  uic_ser_t    tx_st, rx_st;
  logic [10:0] tx_cnt, rx_cnt;
  logic [3:0]  tx_idx, rx_idx;
  logic [8:0]  hold, tx_shift, rx_shift, rx_data;
  logic        hold_full, tx_en, tx_pend, rx_en, rx_pend, rx_ready;
  logic        tx_bit_end, tx_stop_end, tx_load, rx_bit_end, rx_done;
  logic        check_val;
  uic_status_t status;
  uic_codes_t  codes;

  function automatic logic [3:0] pos(input logic [3:0] i,
                                     input logic [3:0] n,
                                     input logic       msb);
    return msb ? 4'(n - 4'h1 - i) : i;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {rxd_s1, rxd_s2} <= 2'h3;
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
    end
    else
    begin
      rxd_s1 <= rxd_i;
      rxd_s2 <= rxd_s1;
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave; one wait state, so pready comes in the second access cycle
  assign access = psel_i & penable_i;
  assign commit = access & pready_o;
  assign wr     = commit & pwrite_i;
  assign rd     = commit & ~pwrite_i;
  assign cmd    = (wr && paddr_i == OFS_CONTROL) ? pwdata_i : 32'h0;

  assign status = '{all_done_flag: tx_en & ~hold_full & (tx_st == SER_IDLE),
                    holding_free_flag: tx_en & ~hold_full,
                    rx_on: rx_en, tx_on: tx_en, rx_ready: rx_ready,
                    default: '0};
  assign codes  = '{fi_value: uic_fi_decode(clock_division_code),
                    di_value: uic_di_decode(bit_rate_adjust_code),
                    bit_rate_adjust_code: bit_rate_adjust_code,
                    clock_division_code: clock_division_code,
                    default: '0};

  always_comb
  begin
    hit    = 1'b1;
    rd_val = 32'h0;
    unique case (paddr_i)
      OFS_CONTROL, OFS_HOLDING: rd_val = 32'h0;
      OFS_MODE:   rd_val = mode;
      OFS_STATUS: rd_val = status;
      OFS_RXDATA: rd_val = {23'h0, rx_data};
      OFS_BAUD:   rd_val = {16'h0, baud_divisor};
      OFS_RATIO:  rd_val = {21'h0, clock_to_bit_ratio};
      OFS_CODES:  rd_val = codes;
      default:    hit    = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= access & ~pready_o;
      prdata_o  <= (access & ~pready_o & ~pwrite_i) ? rd_val : 32'h0;
      pslverr_o <= access & ~pready_o & ~hit;
    end
  end

  // Configuration survives both soft resets
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode                 <= '0;
      baud_divisor         <= BAUD_RESET;
      clock_to_bit_ratio   <= RATIO_RESET;
      clock_division_code  <= CODE_RESET;
      bit_rate_adjust_code <= CODE_RESET;
    end
    else if (wr)
    begin
      if (paddr_i == OFS_MODE)
        mode <= uic_mode_t'(pwdata_i & MODE_WMASK);
      if (paddr_i == OFS_BAUD)
        baud_divisor <= pwdata_i[15:0];
      if (paddr_i == OFS_RATIO)
        clock_to_bit_ratio <= pwdata_i[10:0];
      if (paddr_i == OFS_CODES)
      begin
        clock_division_code  <= pwdata_i[3:0];
        bit_rate_adjust_code <= pwdata_i[7:4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator and card clock
  assign pre_tick = (pre_cnt == PW'(PRESCALE - 1));

  always_comb
  begin
    if (mode.baud_source_select == SRC_SYS)
      src_tick = 1'b1;
    else if (mode.baud_source_select == SRC_DIV)
      src_tick = pre_tick;
    else
      src_tick = sck_s2 & ~sck_s3;
  end

  assign baud_tick = src_tick && baud_divisor != 16'h0 &&
                     baud_cnt >= 16'(baud_divisor - 16'h1);
  // Card mode samples once per card clock period, on its rising edge
  assign samp_tick = mode.iso_mode ? (baud_tick & ~sck_o) : baud_tick;
  assign ovs = mode.iso_mode ? clock_to_bit_ratio :
               (mode.sample_halve ? OVS_HALF : OVS_FULL);

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pre_cnt    <= '0;
      baud_cnt   <= 16'h0;
      sck_o      <= 1'b0;
      sck_oe_n_o <= 1'b1;
    end
    else
    begin
      pre_cnt <= pre_tick ? '0 : PW'(pre_cnt + 1'b1);
      if (baud_tick)
        baud_cnt <= 16'h0;
      else if (src_tick)
        baud_cnt <= 16'(baud_cnt + 16'h1);
      if (baud_tick)
        sck_o <= ~sck_o;
      // External source means the pin is an input
      sck_oe_n_o <= ~(mode.card_clock_output & ~mode.baud_source_select[1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character format; length, mask and check enable shared, stop length and check value transmitter only
  assign nbits = mode.nine_bit_select ? BITS_NINE :
                 4'(BITS_BASE + {2'h0, mode.char_length});
  assign dmask = 9'h1ff >> (BITS_NINE - nbits);
  assign check_on = (mode.check_bit_type <= CHK_MARK);

  always_comb
  begin
    unique case (mode.check_bit_type)
      CHK_EVEN: check_val = ^(tx_shift & dmask);
      CHK_ODD:  check_val = ~^(tx_shift & dmask);
      CHK_MARK: check_val = 1'b1;
      default:  check_val = 1'b0;
    endcase
  end

  always_comb
  begin
    stop_len = {1'b0, ovs};
    if (mode.stop_bit_count == STOP_TWO)
      stop_len = {ovs, 1'b0};
    else if (mode.stop_bit_count == STOP_ONEHALF && !mode.iso_mode)
      stop_len = 12'({1'b0, ovs} + {2'h0, ovs[10:1]});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  assign tx_bit_end  = samp_tick && ({1'b0, tx_cnt} + 12'h1 >= {1'b0, ovs});
  assign tx_stop_end = samp_tick && tx_st == SER_STOP &&
                       ({1'b0, tx_cnt} + 12'h1 >= stop_len);
  // Next character follows the stop bits directly
  assign tx_load = hold_full && tx_en &&
                   ((tx_st == SER_IDLE && samp_tick) || tx_stop_end);

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_en   <= 1'b0;
      tx_pend <= 1'b0;
    end
    else if (cmd[CR_TX_DIS])
      tx_pend <= 1'b1;
    else if (cmd[CR_TX_EN])
    begin
      tx_en   <= 1'b1;
      tx_pend <= 1'b0;
    end
    else if (tx_pend && !hold_full && tx_st == SER_IDLE)
    begin
      tx_en   <= 1'b0;
      tx_pend <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hold_full <= 1'b0;
      hold      <= 9'h0;
    end
    else if (cmd[CR_TX_SRST])
      hold_full <= 1'b0;
    else if (tx_load)
      hold_full <= 1'b0;
    else if (wr && paddr_i == OFS_HOLDING && tx_en && !hold_full)
    begin
      hold_full <= 1'b1;
      hold      <= pwdata_i[8:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_st    <= SER_IDLE;
      tx_cnt   <= 11'h0;
      tx_idx   <= 4'h0;
      tx_shift <= 9'h0;
      txd_o    <= 1'b1;
    end
    else if (cmd[CR_TX_SRST])
    begin
      tx_st <= SER_IDLE;
      txd_o <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_st    <= SER_START;
      tx_cnt   <= 11'h0;
      tx_shift <= hold;
      txd_o    <= 1'b0;
    end
    else if (samp_tick)
    begin
      tx_cnt <= tx_bit_end ? 11'h0 : 11'(tx_cnt + 11'h1);
      unique case (tx_st)
        SER_IDLE:
          tx_cnt <= 11'h0;
        SER_START:
          if (tx_bit_end)
          begin
            tx_st  <= SER_DATA;
            tx_idx <= 4'h0;
            txd_o  <= tx_shift[pos(4'h0, nbits, mode.bit_order_select)];
          end
        SER_DATA:
          if (tx_bit_end)
          begin
            if (tx_idx == 4'(nbits - 4'h1))
            begin
              tx_st <= check_on ? SER_CHECK : SER_STOP;
              txd_o <= check_on ? check_val : 1'b1;
            end
            else
            begin
              tx_idx <= 4'(tx_idx + 4'h1);
              txd_o  <= tx_shift[pos(4'(tx_idx + 4'h1), nbits,
                                     mode.bit_order_select)];
            end
          end
        SER_CHECK:
          if (tx_bit_end)
          begin
            tx_st <= SER_STOP;
            txd_o <= 1'b1;
          end
        SER_STOP:
        begin
          tx_cnt <= 11'(tx_cnt + 11'h1);
          if (tx_stop_end)
            tx_st <= SER_IDLE;
        end
        default:
          tx_st <= SER_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous receiver; check bit time is skipped, neither sampled nor judged here
  assign rx_bit_end = samp_tick && ({1'b0, rx_cnt} + 12'h1 >= {1'b0, ovs});
  assign rx_done    = rx_st == SER_STOP && rx_bit_end;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_en   <= 1'b0;
      rx_pend <= 1'b0;
    end
    else if (cmd[CR_RX_DIS])
      rx_pend <= 1'b1;
    else if (cmd[CR_RX_EN])
    begin
      rx_en   <= 1'b1;
      rx_pend <= 1'b0;
    end
    else if (rx_pend && rx_st == SER_IDLE)
    begin
      rx_en   <= 1'b0;
      rx_pend <= 1'b0;
    end
  end

  // A character landing with the data read still sets the flag
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rx_ready <= 1'b0;
    else if (cmd[CR_RX_SRST])
      rx_ready <= 1'b0;
    else if (rx_done)
      rx_ready <= 1'b1;
    else if (rd && paddr_i == OFS_RXDATA)
      rx_ready <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_st    <= SER_IDLE;
      rx_cnt   <= 11'h0;
      rx_idx   <= 4'h0;
      rx_shift <= 9'h0;
      rx_data  <= 9'h0;
    end
    else if (cmd[CR_RX_SRST])
    begin
      rx_st  <= SER_IDLE;
      rx_cnt <= 11'h0;
    end
    else if (samp_tick)
    begin
      rx_cnt <= rx_bit_end ? 11'h0 : 11'(rx_cnt + 11'h1);
      unique case (rx_st)
        SER_IDLE:
          if (!rx_en || rx_pend || rxd_s2)
            rx_cnt <= 11'h0;
          else if ({1'b0, rx_cnt} + 12'h1 >= {2'h0, ovs[10:1]})
          begin
            rx_st    <= SER_DATA;
            rx_cnt   <= 11'h0;
            rx_idx   <= 4'h0;
            rx_shift <= 9'h0;
          end
        SER_DATA:
          if (rx_bit_end)
          begin
            rx_shift[pos(rx_idx, nbits, mode.bit_order_select)]
              <= rxd_s2;
            rx_idx <= 4'(rx_idx + 4'h1);
            if (rx_idx == 4'(nbits - 4'h1))
              rx_st <= check_on ? SER_CHECK : SER_STOP;
          end
        SER_CHECK:
          if (rx_bit_end)
            rx_st <= SER_STOP;
        SER_STOP:
          if (rx_bit_end)
          begin
            rx_st   <= SER_IDLE;
            rx_data <= rx_shift & dmask;
          end
        default:
          rx_st <= SER_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- uic_pkg.sv ----
// Constants, field layouts and code tables of the ISO 7816 capable USART
// Function
// - Rate adjust code 1,2,3,4,5,6,8,9 decodes to 1,2,4,8,16,32,12,20.
// - Division codes 0-6, 9-13 decode to 372 through 2048.
// - Card mode divides selected source by twice the baud divisor; may drive clock pin.
// - Card mode divides card clock by ratio, up to 2047, giving bit time.
// - Ratio field resets to 0x174, that is 372.
// - Receiver and transmitter start disabled; each enabled by its own command.
// - Soft resets stop traffic at once, clear flags, keep configuration.
// - Receive disable lets the character in progress finish first.
// - Transmit disable finishes current and held character first.
// - Transmitter sends start, up to 9 data, optional check, stop bits.
// - Length field sets data bits; nine-bit select forces nine.
// - Bit order select 1 sends MSB first, 0 LSB first.
// - Check bit even, odd, space, mark, none; 1.5 stop async only.
// - Character end loads held one, frees holding; all-done when idle.
// - Holding free and all done stay low while transmitter disabled.
// - Holding register write while not free is dropped.
// - Async receiver oversamples 16x, or 8x with halve bit set.
// - Start taken at half bit of lows; then one sample per bit.
// - Receiver uses transmitter length, order and check bit settings.
// - Receiver times only one stop bit; its level is not checked.
// - After stop sample receiver hunts next start at once.
// - Baud divisor 0 gives no clock; 1 bypasses the divider.
package uic_pkg;

  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODE    = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_RXDATA  = 8'h0c;
  localparam logic [7:0] OFS_HOLDING = 8'h10;
  localparam logic [7:0] OFS_BAUD    = 8'h14;
  localparam logic [7:0] OFS_RATIO   = 8'h18;
  localparam logic [7:0] OFS_CODES   = 8'h1c;

  localparam int CR_RX_SRST = 2;
  localparam int CR_TX_SRST = 3;
  localparam int CR_RX_EN   = 4;
  localparam int CR_RX_DIS  = 5;
  localparam int CR_TX_EN   = 6;
  localparam int CR_TX_DIS  = 7;

  localparam logic [31:0] MODE_WMASK  = 32'h000f_37f1;
  localparam logic [10:0] RATIO_RESET = 11'h174;
  localparam logic [15:0] BAUD_RESET  = 16'h0000;
  localparam logic [3:0]  CODE_RESET  = 4'h1;
  localparam logic [10:0] OVS_FULL    = 11'h010;
  localparam logic [10:0] OVS_HALF    = 11'h008;
  localparam logic [3:0]  BITS_NINE   = 4'h9;
  localparam logic [3:0]  BITS_BASE   = 4'h5;

  localparam logic [2:0] CHK_EVEN  = 3'h0;
  localparam logic [2:0] CHK_ODD   = 3'h1;
  localparam logic [2:0] CHK_SPACE = 3'h2;
  localparam logic [2:0] CHK_MARK  = 3'h3;
  localparam logic [1:0] STOP_ONEHALF = 2'h1;
  localparam logic [1:0] STOP_TWO     = 2'h2;
  localparam logic [1:0] SRC_SYS = 2'h0;
  localparam logic [1:0] SRC_DIV = 2'h1;

  typedef struct packed {
    logic [11:0] pad_hi;
    logic        sample_halve;
    logic        card_clock_output;
    logic        nine_bit_select;
    logic        bit_order_select;
    logic [1:0]  pad_mid;
    logic [1:0]  stop_bit_count;
    logic        pad_chk;
    logic [2:0]  check_bit_type;
    logic [1:0]  char_length;
    logic [1:0]  baud_source_select;
    logic [2:0]  pad_lo;
    logic        iso_mode;
  } uic_mode_t;

  typedef struct packed {
    logic [21:0] pad_hi;
    logic        all_done_flag;
    logic [2:0]  pad_mid;
    logic        rx_on;
    logic        tx_on;
    logic [1:0]  pad_lo;
    logic        holding_free_flag;
    logic        rx_ready;
  } uic_status_t;

  typedef struct packed {
    logic [3:0]  pad_hi;
    logic [11:0] fi_value;
    logic [1:0]  pad_mid;
    logic [5:0]  di_value;
    logic [3:0]  bit_rate_adjust_code;
    logic [3:0]  clock_division_code;
  } uic_codes_t;

  typedef enum logic [2:0] {
    SER_IDLE, SER_START, SER_DATA, SER_CHECK, SER_STOP
  } uic_ser_t;

  function automatic logic [5:0] uic_di_decode(input logic [3:0] c);
    unique case (c)
      4'h1:    return 6'h01;
      4'h2:    return 6'h02;
      4'h3:    return 6'h04;
      4'h4:    return 6'h08;
      4'h5:    return 6'h10;
      4'h6:    return 6'h20;
      4'h8:    return 6'h0c;
      4'h9:    return 6'h14;
      default: return 6'h00;
    endcase
  endfunction

  function automatic logic [11:0] uic_fi_decode(input logic [3:0] c);
    unique case (c)
      4'h0, 4'h1: return 12'h174;
      4'h2:    return 12'h22e;
      4'h3:    return 12'h2e8;
      4'h4:    return 12'h45c;
      4'h5:    return 12'h5d0;
      4'h6:    return 12'h744;
      4'h9:    return 12'h200;
      4'ha:    return 12'h300;
      4'hb:    return 12'h400;
      4'hc:    return 12'h600;
      4'hd:    return 12'h800;
      default: return 12'h000;
    endcase
  endfunction

endpackage

// ---- uic_usart_properties.sv ----
// Port-level assertions for the USART core, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module uic_usart_properties (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        rxd_i,
  input wire logic        txd_o,
  input wire logic        sck_i,
  input wire logic        sck_o,
  input wire logic        sck_oe_n_o
);
  import uic_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Shadow of the settings, rebuilt from completed bus writes
  logic        wr_ok, tx_seen, rat_wr, oe_want, fast;
  logic [15:0] baud;
  uic_mode_t   mode;
  assign wr_ok = psel_i && penable_i && pready_o && pwrite_i;
  assign oe_want = mode.card_clock_output && !mode.baud_source_select[1];
  // Only the plain 16x, one-cycle tick case gives an exact bit length
  assign fast = baud == 16'h1 && mode.baud_source_select == SRC_SYS &&
                !mode.iso_mode && !mode.sample_halve;
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      baud <= BAUD_RESET;
      mode <= '0;
      {tx_seen, rat_wr} <= 2'h0;
    end
    else if (wr_ok)
    begin
      case (paddr_i)
        OFS_BAUD:    baud <= pwdata_i[15:0];
        OFS_MODE:    mode <= uic_mode_t'(pwdata_i & MODE_WMASK);
        OFS_RATIO:   rat_wr <= 1'h1;
        OFS_CONTROL: tx_seen <= tx_seen | pwdata_i[CR_TX_EN];
        default:     ;
      endcase
    end
  ////////////////////////////////////////
  chk_ready_wait: assert property
    ($rose(penable_i) && psel_i |=> pready_o ##1 !pready_o)
    else $error("pready not one pulse after one wait");
  chk_err_decode: assert property
    (pready_o |-> pslverr_o == (paddr_i > OFS_CODES))
    else $error("pslverr does not match address decode");
  chk_data_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero outside answer");
  chk_baud_still: assert property (
    baud == 16'h0 && $past(baud) == 16'h0 |-> $stable(sck_o))
    else $error("clock moves with zero divisor");
  chk_baud_bypass: assert property (
    baud == 16'h1 && $past(baud) == 16'h1 && $past(baud, 2) == 16'h1 &&
    mode.baud_source_select == SRC_SYS |-> $changed(sck_o))
    else $error("clock idle with divisor one");
  chk_pin_drive: assert property (sck_oe_n_o == !$past(oe_want))
    else $error("clock pin enable wrong");
  chk_txd_quiet: assert property (!tx_seen |-> txd_o)
    else $error("txd active before transmit enable");
  chk_start_len: assert property (
    $fell(txd_o) && fast |-> (!txd_o)[*8] ##1 (!txd_o)[*8])
    else $error("start bit too short");
  chk_flags_off: assert property (
    pready_o && !pwrite_i && paddr_i == OFS_STATUS && !tx_seen
    |-> prdata_o[1] == 1'h0 && prdata_o[9] == 1'h0)
    else $error("tx flags high while disabled");
  chk_ratio_reset: assert property (
    pready_o && !pwrite_i && paddr_i == OFS_RATIO && !rat_wr
    |-> prdata_o[10:0] == RATIO_RESET)
    else $error("ratio reset value wrong");
  cov_tx_start: cover property ($fell(txd_o));
  cov_bus_err: cover property (pslverr_o);
  cov_pin_drive: cover property (!sck_oe_n_o);
endmodule
bind uic_usart uic_usart_properties u_props (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .rxd_i(rxd_i), .txd_o(txd_o), .sck_i(sck_i),
  .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o));
`default_nettype wire

// ---- uic_peer.sv ----
// Remote serial transceiver model facing the USART pins
`timescale 1ns/1ps
`default_nettype none
module uic_peer (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output var  logic rxd_o
);
  initial rxd_o = 1'h1;
  // Frame ends on its stop bit, so the line rests high afterwards
  task automatic send(input logic [11:0] f, input int n, input int bl);
    for (int i = 0; i < n; i++)
    begin
      rxd_o <= f[i];
      repeat (bl) @(posedge clk_i);
    end
  endtask
  // Samples mid-bit on falling edges, clear of the pin's update edge
  task automatic grab(output logic [11:0] f, input int n, input int bl);
    int k;
    f = 12'hfff;
    k = 0;
    while (txd_i === 1'h1 && k < 4000)
    begin
      @(negedge clk_i);
      k++;
    end
    repeat (bl / 2) @(negedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      f[i] = txd_i;
      if (i < n - 1)
        repeat (bl) @(negedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the USART core
`timescale 1ns/1ps
`default_nettype none
module tb;
  import uic_pkg::*;
  logic        sys_clk, rst, psel, pen, pwr, pready, pslverr, rxd, txd;
  logic        sck, sck_oe_n, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdat;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  localparam logic [11:0] FIT [16] = '{12'h174, 12'h174, 12'h22e, 12'h2e8,
    12'h45c, 12'h5d0, 12'h744, 12'h0, 12'h0, 12'h200, 12'h300, 12'h400,
    12'h600, 12'h800, 12'h0, 12'h0};
  localparam logic [5:0] DIT [16] = '{6'h0, 6'h1, 6'h2, 6'h4, 6'h8, 6'h10,
    6'h20, 6'h0, 6'hc, 6'h14, 6'h0, 6'h0, 6'h0, 6'h0, 6'h0, 6'h0};
  localparam int CL [5] = '{3, 2, 0, 1, 0};
  localparam int CK [5] = '{4, 0, 1, 3, 2};
  uic_usart #(.PRESCALE(8)) dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rxd_i(rxd), .txd_o(txd),
    .sck_i(1'h0), .sck_o(sck), .sck_oe_n_o(sck_oe_n));
  uic_peer peer (.clk_i(sys_clk), .txd_i(txd), .rxd_o(rxd));
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Starts on a fresh edge so back-to-back calls never clash
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    {psel, pwr, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge sys_clk);
    pen <= 1'h1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'h1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    {psel, pen} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  function automatic logic [31:0] mw(input int cl, ck, ms, nn, hv, iso);
    uic_mode_t m;
    m = '0;
    m.char_length = 2'(cl);
    m.check_bit_type = 3'(ck);
    m.bit_order_select = ms[0];
    m.nine_bit_select = nn[0];
    m.sample_halve = hv[0];
    m.iso_mode = iso[0];
    m.card_clock_output = iso[0];
    return m;
  endfunction
  // Wire order: start, data, optional check bit, stop ones above
  function automatic logic [11:0] frm(input logic [8:0] d, input int nb,
                                      ms, ck);
    logic [11:0] f;
    logic        p;
    f = 12'hffe;
    p = ^(d & 9'((1 << nb) - 1));
    for (int i = 0; i < nb; i++)
      f[i + 1] = ms[0] ? d[nb - 1 - i] : d[i];
    if (ck < 4)
      f[nb + 1] = (ck == 0) ? p : (ck == 1) ? !p : (ck == 3);
    return f;
  endfunction
  task automatic txpair(input logic [8:0] a, b, input int nb, ms, ck, bl, dis);
    logic [11:0] fa;
    logic [11:0] fb;
    int          n;
    n = nb + 2 + int'(ck < 4);
    fork
      begin
        peer.grab(fa, n, bl);
        peer.grab(fb, n, bl);
      end
      begin
        wr(OFS_HOLDING, {23'h0, a});
        repeat (8) @(posedge sys_clk);
        wr(OFS_HOLDING, {23'h0, b});
        if (dis != 0)
          wr(OFS_CONTROL, 32'h80);
      end
    join
    cmp("frame a", {20'h0, frm(a, nb, ms, ck)}, {20'h0, fa});
    cmp("frame b", {20'h0, frm(b, nb, ms, ck)}, {20'h0, fb});
  endtask
  ////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      close_out();
    end
  end
  initial
  begin
    {psel, pen, pwr, paddr, pwdata} = 43'h0;
    rst = 1'h1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    rd(OFS_RATIO);
    cmp("ratio", 32'h174, rdat);
    rd(OFS_STATUS);
    cmp("status", 32'h0, rdat & 32'h232);
    rd(8'h20);
    cmp("unmapped", 32'h1, {31'h0, rerr});
    for (int i = 0; i < 16; i++)
    begin
      wr(OFS_CODES, {24'h0, 4'(i), 4'(i)});
      rd(OFS_CODES);
      cmp("code", {4'h0, FIT[i], 2'h0, DIT[i], 4'(i), 4'(i)}, rdat);
    end
    $display("test reset and code tables done");
    wr(OFS_HOLDING, 32'h55);
    wr(OFS_BAUD, 32'h1);
    wr(OFS_CONTROL, 32'h40);
    rd(OFS_STATUS);
    cmp("status", 32'h212, rdat & 32'h232);
    cmp("txd idle", 32'h1, {31'h0, txd});
    for (int i = 0; i < 5; i++)
    begin
      wr(OFS_MODE, mw(CL[i], CK[i], i % 2, i == 2, 0, 0));
      txpair(9'h1a5 >> i, 9'h0c3 + 9'(i), (i == 2) ? 9 : CL[i] + 5,
             i % 2, CK[i], 16, 0);
    end
    repeat (20) @(posedge sys_clk);
    rd(OFS_STATUS);
    cmp("status", 32'h212, rdat & 32'h212);
    $display("test transmit done");
    wr(OFS_CONTROL, 32'h10);
    for (int h = 0; h < 2; h++)
    begin
      wr(OFS_MODE, mw(3, 0, 1, 0, h, 0));
      peer.send(frm(9'h3c, 8, 1, 0), 11, 16 >> h);
      fork
        peer.send(frm(9'hc3, 8, 1, 0), 11, 16 >> h);
      join_none
      rd(OFS_RXDATA);
      cmp("rx first", 32'h3c, rdat);
      repeat (11 * (16 >> h) + 16) @(posedge sys_clk);
      rd(OFS_RXDATA);
      cmp("rx second", 32'hc3, rdat);
    end
    fork
      peer.send(frm(9'h96, 8, 1, 0), 11, 8);
    join_none
    repeat (24) @(posedge sys_clk);
    wr(OFS_CONTROL, 32'h20);
    repeat (80) @(posedge sys_clk);
    rd(OFS_RXDATA);
    cmp("rx across disable", 32'h96, rdat);
    rd(OFS_STATUS);
    cmp("rx off", 32'h0, rdat & 32'h20);
    $display("test receive done");
    txpair(9'h81, 9'h7e, 8, 1, 0, 8, 1);
    repeat (20) @(posedge sys_clk);
    rd(OFS_STATUS);
    cmp("tx off", 32'h0, rdat & 32'h212);
    wr(OFS_CONTROL, 32'h40);
    wr(OFS_HOLDING, 32'h0);
    repeat (30) @(posedge sys_clk);
    wr(OFS_CONTROL, 32'h08);
    repeat (2) @(posedge sys_clk);
    cmp("txd after soft reset", 32'h1, {31'h0, txd});
    rd(OFS_MODE);
    cmp("mode kept", mw(3, 0, 1, 0, 1, 0), rdat);
    $display("test disable and soft reset done");
    wr(OFS_MODE, mw(3, 4, 0, 0, 0, 1));
    wr(OFS_BAUD, 32'h2);
    // Integer ratio only; four card clocks per bit
    wr(OFS_RATIO, 32'h4);
    repeat (2) @(posedge sys_clk);
    cmp("pin drive", 32'h0, {31'h0, sck_oe_n});
    txpair(9'h5a, 9'h99, 8, 0, 4, 16, 0);
    $display("test card rate done");
    close_out();
  end
endmodule
`default_nettype wire
